// File: rtc_trim_map.svh
`ifndef RTC_TRIM_MAP_SVH
`define RTC_TRIM_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_TRIM_LO    4'h0
`define OFF_TRIM_HI    4'h1
`define OFF_TRIM_EN    4'h2
`define OFF_DIV_RATIO  4'h3
`define OFF_DIV_CTRL   4'h4
`define OFF_TRIM_PRD   4'h5
`define OFF_PULSE_SEL  4'h6
`define OFF_XFER_CTRL  4'h7
`define OFF_XFER_STAT  4'h8
`define NUM_BUF_REGS   7

// ****************************************
// Writable field masks and reset value
// ****************************************
`define MSK_TRIM_LO    8'hFF
`define MSK_TRIM_HI    8'h03
`define MSK_TRIM_EN    8'h01
`define MSK_DIV_RATIO  8'h0F
`define MSK_DIV_CTRL   8'h01
`define MSK_TRIM_PRD   8'h3F
`define MSK_PULSE_SEL  8'h01
`define BUF_RST        8'h00

// ****************************************
// Field positions
// ****************************************
`define BIT_TRIM_EN    0
`define BIT_DIV_EN     0
`define BIT_DIV_RUN    1
`define BIT_PULSE_SEL  0
`define BIT_SAVE       0
`define BIT_RECALL     1
`define BIT_PEND       0
`define TRIM_W         10
`define PRD_W          6
`define RATIO_W        4

// ****************************************
// Timing counts
// ****************************************
`define XFER_CYCLES    8
`define SUB_PER_SEC    32768

`endif

// File: rtc_trim_pkg.sv
package rtc_trim_pkg;

    typedef logic [3:0] reg_addr_t;
    typedef logic [7:0] reg_byte_t;

    typedef enum logic [2:0] {
        XF_IDLE   = 3'b001,
        XF_SAVE   = 3'b010,
        XF_RECALL = 3'b100
    } xfer_state_t;

endpackage

// File: backup_bank.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Battery-side copy of the setting bytes
// ****************************************
module backup_bank #(
    parameter int unsigned NREG = 7
) (
    input  wire logic                core_clk,
    input  wire logic                vbat_rstn,
    input  wire logic                save_en,
    input  wire logic [NREG*8-1:0]   data_in,
    output logic      [NREG*8-1:0]   data_out
);

    logic [NREG*8-1:0] store_q;

    // Only the battery reset clears this copy
    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            store_q <= '0;
        end else if (save_en) begin
            store_q <= data_in;
        end
    end

    assign data_out = store_q;

endmodule

`default_nettype wire

// File: rtc_clock_trim_and_divider.sv
// Contract
// - Trim count is ten bits: low byte plus two bits of the high byte.
// - With trimming on, drop trim-count sub pulses per period; pass the rest.
// - Period 19 and trim 8 drop 8 pulses every 20 seconds.
// - Six-bit period field gives a period of setting plus one seconds.
// - Trim enable bit 0 off passes every sub clock pulse.
// - Reserved bits of every register read as zero.
// - Ratio code n divides by two to the n; zero means undivided.
// - Running flag bit 1 is 0 with pin low when stopped, 1 running.
// - Divider enable bit 0 stops the divider when clear, starts when set.
// - Pulse select 0 drives the carry pulse, 1 drives it halved.
// - Pulse pin carries a half-second or one-second signal.
// - The rstn reset clears the shadow buffers but keeps the battery copies.
// - Deep standby gives no divided clock on the divided pin.
// - Deep standby gives no signal on the pulse pin.
// - Period counter underflow reloads the saved period and keeps counting.
// - Dropped pulses stretch the carry interval by their time.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_trim_map.svh"

module rtc_clock_trim_and_divider #(
    parameter int unsigned SUB_PER_SEC = `SUB_PER_SEC
) (
    input  wire logic                    core_clk,
    input  wire logic                    rstn,
    input  wire logic                    vbat_rstn,
    input  wire logic                    sub_clk_in,
    input  wire logic                    half_second_carry_pulse,
    input  wire logic                    deep_standby,
    input  wire rtc_trim_pkg::reg_addr_t reg_addr,
    input  wire rtc_trim_pkg::reg_byte_t reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output rtc_trim_pkg::reg_byte_t      reg_rdata,
    output logic                         trimmed_rtc_clock,
    output logic                         divided_output_pin,
    output logic                         pulse_pin
);
    import rtc_trim_pkg::*;

    localparam int NREG = `NUM_BUF_REGS;
    localparam int SW   = $clog2(SUB_PER_SEC);
    localparam int DW   = 15;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] field_mask(input logic [3:0] a);
        case (a)
            `OFF_TRIM_LO:   field_mask = `MSK_TRIM_LO;
            `OFF_TRIM_HI:   field_mask = `MSK_TRIM_HI;
            `OFF_TRIM_EN:   field_mask = `MSK_TRIM_EN;
            `OFF_DIV_RATIO: field_mask = `MSK_DIV_RATIO;
            `OFF_DIV_CTRL:  field_mask = `MSK_DIV_CTRL;
            `OFF_TRIM_PRD:  field_mask = `MSK_TRIM_PRD;
            `OFF_PULSE_SEL: field_mask = `MSK_PULSE_SEL;
            default:        field_mask = 8'h00;
        endcase
    endfunction

    function automatic logic div_tap(input logic [DW-1:0] cnt,
                                     input logic [3:0] ratio,
                                     input logic sub);
        if (ratio == 4'h0) begin
            div_tap = sub;
        end else begin
            div_tap = cnt[4'(ratio - 4'h1)];
        end
    endfunction

    // ****************************************
    // Shadow buffers and transfer control
    // ****************************************
    logic [NREG-1:0][7:0] buf_q;
    logic [NREG*8-1:0]    bat_flat;
    xfer_state_t          xf_q;
    logic [2:0]           xf_cnt_q;
    logic                 xf_pend;
    logic                 xf_done;
    logic                 wr_buf;
    logic                 wr_xfer;

    assign wr_buf  = reg_wr && (reg_addr < 4'(NREG));
    assign wr_xfer = reg_wr && (reg_addr == `OFF_XFER_CTRL);
    assign xf_pend = (xf_q != XF_IDLE);
    assign xf_done = xf_pend && (xf_cnt_q == 3'h0);

    // Only rstn clears these buffers; the battery copy is kept and recall refills them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            buf_q <= {NREG{`BUF_RST}};
        end else if ((xf_q == XF_RECALL) && xf_done) begin
            buf_q <= bat_flat;
        end else if (wr_buf) begin
            buf_q[reg_addr[2:0]] <= reg_wdata & field_mask(reg_addr);
        end
    end

    // Save or recall takes a fixed number of cycles; requests while busy are ignored
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            xf_q     <= XF_IDLE;
            xf_cnt_q <= 3'h0;
        end else begin
            case (xf_q)
                XF_IDLE: begin
                    if (wr_xfer && reg_wdata[`BIT_SAVE]) begin
                        xf_q     <= XF_SAVE;
                        xf_cnt_q <= 3'(`XFER_CYCLES - 1);
                    end else if (wr_xfer && reg_wdata[`BIT_RECALL]) begin
                        xf_q     <= XF_RECALL;
                        xf_cnt_q <= 3'(`XFER_CYCLES - 1);
                    end
                end
                XF_SAVE, XF_RECALL: begin
                    if (xf_done) begin
                        xf_q <= XF_IDLE;
                    end else begin
                        xf_cnt_q <= xf_cnt_q - 3'h1;
                    end
                end
                default: begin
                    xf_q <= XF_IDLE;
                end
            endcase
        end
    end

    backup_bank #(
        .NREG (NREG)
    ) u_bank (
        .core_clk  (core_clk),
        .vbat_rstn (vbat_rstn),
        .save_en   ((xf_q == XF_SAVE) && xf_done),
        .data_in   (buf_q),
        .data_out  (bat_flat)
    );

    // Battery-side settings that steer the logic
    logic [7:0]         trim_lo_b;
    logic [7:0]         trim_hi_b;
    logic               trim_en_b;
    logic [3:0]         ratio_b;
    logic               div_en_b;
    logic [`PRD_W-1:0]  prd_b;
    logic               sel_b;
    logic [`TRIM_W-1:0] trim_count_value;

    assign trim_lo_b = bat_flat[8*`OFF_TRIM_LO +: 8];
    assign trim_hi_b = bat_flat[8*`OFF_TRIM_HI +: 8];
    assign trim_en_b = bat_flat[8*`OFF_TRIM_EN + `BIT_TRIM_EN];
    assign ratio_b   = bat_flat[8*`OFF_DIV_RATIO +: `RATIO_W];
    assign div_en_b  = bat_flat[8*`OFF_DIV_CTRL + `BIT_DIV_EN];
    assign prd_b     = bat_flat[8*`OFF_TRIM_PRD +: `PRD_W];
    assign sel_b     = bat_flat[8*`OFF_PULSE_SEL + `BIT_PULSE_SEL];
    assign trim_count_value = {trim_hi_b[1:0], trim_lo_b};

    // ****************************************
    // Frequency trim
    // ****************************************
    logic               sub_prev_q;
    logic               sub_rise;
    logic [SW-1:0]      sec_cnt_q;
    logic               sec_tick;
    logic [`PRD_W-1:0]  prd_cnt_q;
    logic               prd_start;
    logic [`TRIM_W-1:0] mask_left_q;
    logic               suppress;
    logic               hold_q;
    logic               trimmed_q;

    assign sub_rise  = sub_clk_in && !sub_prev_q;
    assign sec_tick  = sub_rise && (sec_cnt_q == SW'(SUB_PER_SEC - 1));
    assign prd_start = sec_tick && trim_en_b && (prd_cnt_q == '0);
    assign suppress  = trim_en_b && (mask_left_q != '0);

    // Seconds are counted on every raw sub clock pulse
    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            sub_prev_q <= 1'b0;
            sec_cnt_q  <= '0;
        end else begin
            sub_prev_q <= sub_clk_in;
            if (sec_tick) begin
                sec_cnt_q <= '0;
            end else if (sub_rise) begin
                sec_cnt_q <= sec_cnt_q + SW'(1);
            end
        end
    end

    // Period runs from setting down to zero, one step per second
    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            prd_cnt_q <= '0;
        end else if (prd_start) begin
            prd_cnt_q <= prd_b;
        end else if (sec_tick && trim_en_b) begin
            prd_cnt_q <= prd_cnt_q - `PRD_W'(1);
        end
    end

    // The first pulses of each period are swallowed
    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            mask_left_q <= '0;
        end else if (!trim_en_b) begin
            mask_left_q <= '0;
        end else if (prd_start) begin
            mask_left_q <= trim_count_value;
        end else if (sub_rise && suppress) begin
            mask_left_q <= mask_left_q - `TRIM_W'(1);
        end
    end

    // A swallowed pulse stays low for its whole high phase
    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            hold_q    <= 1'b0;
            trimmed_q <= 1'b0;
        end else begin
            if (sub_rise) begin
                hold_q <= suppress;
            end
            trimmed_q <= sub_clk_in && !(sub_rise ? suppress : hold_q);
        end
    end

    // Downstream counter sees fewer edges, so its carry stretches
    assign trimmed_rtc_clock = trimmed_q;

    // ****************************************
    // Divided output
    // ****************************************
    logic [DW-1:0] div_cnt_q;
    logic          run_q;
    logic          div_level;
    logic          divided_q;

    // Ratio is read live; it is only changed while stopped
    assign div_level = div_tap(div_cnt_q, ratio_b, sub_clk_in);

    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            run_q     <= 1'b0;
            div_cnt_q <= '0;
        end else if (!run_q) begin
            div_cnt_q <= '0;
            run_q     <= div_en_b;
        end else if (!div_en_b && !div_level) begin
            run_q <= 1'b0;
        end else if (sub_rise) begin
            div_cnt_q <= div_cnt_q + DW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            divided_q <= 1'b0;
        end else begin
            divided_q <= run_q && !deep_standby && div_level;
        end
    end

    assign divided_output_pin = divided_q;

    // ****************************************
    // Pulse output
    // ****************************************
    logic carry_prev_q;
    logic half_q;
    logic pulse_q;

    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            carry_prev_q <= 1'b0;
            half_q       <= 1'b0;
        end else begin
            carry_prev_q <= half_second_carry_pulse;
            if (half_second_carry_pulse && !carry_prev_q) begin
                half_q <= !half_q;
            end
        end
    end

    always_ff @(posedge core_clk or negedge vbat_rstn) begin
        if (!vbat_rstn) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= !deep_standby &&
                       (sel_b ? half_q : half_second_carry_pulse);
        end
    end

    assign pulse_pin = pulse_q;

    // ****************************************
    // Register read port
    // ****************************************
    logic [7:0] rdata_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else if (!reg_rd) begin
            rdata_q <= 8'h00;
        end else begin
            case (reg_addr)
                `OFF_TRIM_LO, `OFF_TRIM_HI, `OFF_TRIM_EN, `OFF_DIV_RATIO,
                `OFF_TRIM_PRD, `OFF_PULSE_SEL: begin
                    rdata_q <= buf_q[reg_addr[2:0]] & field_mask(reg_addr);
                end
                `OFF_DIV_CTRL: begin
                    rdata_q <= {6'h00, run_q,
                                buf_q[`OFF_DIV_CTRL][`BIT_DIV_EN]};
                end
                `OFF_XFER_CTRL: begin
                    rdata_q <= {6'h00, xf_q == XF_RECALL, xf_q == XF_SAVE};
                end
                `OFF_XFER_STAT: begin
                    rdata_q <= {7'h00, xf_pend};
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn || !vbat_rstn);

    sequence s_busy;
        xf_pend [*8];
    endsequence

    sequence s_start_sup;
        sub_rise && trim_en_b && (mask_left_q != '0);
    endsequence

    a_xfer_busy_len: assert property ($rose(xf_pend) |-> s_busy ##1 !xf_pend)
        else $error("transfer pending length wrong");

    a_trim_pass_off: assert property (sub_rise && !trim_en_b |=> trimmed_q)
        else $error("pulse lost with trimming off");

    a_trim_mask_first: assert property (s_start_sup |=> !trimmed_q &&
                                        mask_left_q == $past(mask_left_q) - `TRIM_W'(1))
        else $error("masked pulse passed or count wrong");

    a_period_reload: assert property (prd_start |=> prd_cnt_q == $past(prd_b)
                                      && mask_left_q == $past(trim_count_value))
        else $error("period reload wrong");

    a_div_stop_low: assert property (!run_q |-> !divided_q)
        else $error("divided pin high while stopped");

    a_div_halt_low: assert property (run_q && !div_en_b && !div_level
                                     |=> !run_q && !divided_q)
        else $error("divider did not halt");

    a_standby_div: assert property (deep_standby |=> !divided_q)
        else $error("divided clock in standby");

    a_standby_pulse: assert property (deep_standby |=> !pulse_q)
        else $error("pulse pin active in standby");

    a_pulse_direct: assert property (!sel_b && !deep_standby
                                     |=> pulse_q == $past(half_second_carry_pulse))
        else $error("pulse pin not following carry");

    a_reserved_zero: assert property ($past(reg_rd) &&
                                      $past(reg_addr) == `OFF_TRIM_HI |-> reg_rdata[7:2] == 6'h00)
        else $error("reserved bits read nonzero");

endmodule

`default_nettype wire

// File: rtc_far_side.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Sub clock source, count block and pin counters
// ****************************************
module rtc_far_side #(
    parameter int SPS = 8
) (
    input  wire logic        core_clk,
    input  wire logic        trim_clk,
    input  wire logic        div_pin,
    input  wire logic        pulse_pin,
    output logic             sub_clk,
    output logic             carry,
    output logic [31:0]      n_sub,
    output logic [31:0]      n_trim,
    output logic [31:0]      n_div,
    output logic [31:0]      n_pulse
);
    logic [2:0]  ph_q;
    logic [31:0] tick_q;
    logic [2:0]  prev_q;

    initial begin
        ph_q = 3'h0;
        tick_q = 32'h0;
        prev_q = 3'h0;
        sub_clk = 1'b0;
        carry = 1'b0;
        n_sub = 32'h0;
        n_trim = 32'h0;
        n_div = 32'h0;
        n_pulse = 32'h0;
    end

    // Sub clock is eight core cycles long, half high
    always @(posedge core_clk) begin
        ph_q <= ph_q + 3'h1;
        sub_clk <= ph_q[2];
        n_sub <= n_sub + {31'h0, ph_q == 3'h4};
        prev_q <= {trim_clk, div_pin, pulse_pin};
        n_div <= n_div + {31'h0, div_pin & ~prev_q[1]};
        n_pulse <= n_pulse + {31'h0, pulse_pin & ~prev_q[0]};
    end

    // Carry counted on trimmed pulses, so dropped pulses stretch it
    always @(posedge core_clk) begin
        carry <= 1'b0;
        if (trim_clk && !prev_q[2]) begin
            n_trim <= n_trim + 32'h1;
            tick_q <= (tick_q == SPS / 2 - 1) ? 32'h0 : tick_q + 32'h1;
            carry <= (tick_q == SPS / 2 - 1);
        end
    end
endmodule
`default_nettype wire

// File: rtc_clock_trim_and_divider_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "rtc_trim_map.svh"

module rtc_clock_trim_and_divider_test;
    import rtc_trim_pkg::*;
    localparam int SPS = 8;
    logic        core_clk, rstn, vbat_rstn, stby, reg_wr, reg_rd;
    logic        sub_clk, carry, trim_clk, div_pin, pulse_pin;
    reg_addr_t   reg_addr;
    reg_byte_t   reg_wdata, reg_rdata;
    logic [31:0] n_sub, n_trim, n_div, n_pulse;
    int          n_errors, tests_run, d_sub, d_trim, d_div, d_pulse;
    reg_byte_t   msk[7] = '{`MSK_TRIM_LO, `MSK_TRIM_HI, `MSK_TRIM_EN, `MSK_DIV_RATIO,
                            `MSK_DIV_CTRL, `MSK_TRIM_PRD, `MSK_PULSE_SEL};
    int          cfg[5][3] = '{'{0, 2, 5}, '{1, 2, 2}, '{1, 19, 8}, '{1, 0, 3}, '{1, 63, 261}};

    rtc_clock_trim_and_divider #(.SUB_PER_SEC(SPS)) DUT (
        .core_clk(core_clk), .rstn(rstn), .vbat_rstn(vbat_rstn), .sub_clk_in(sub_clk),
        .half_second_carry_pulse(carry), .deep_standby(stby), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trimmed_rtc_clock(trim_clk), .divided_output_pin(div_pin), .pulse_pin(pulse_pin));

    rtc_far_side #(.SPS(SPS)) far (
        .core_clk(core_clk), .trim_clk(trim_clk), .div_pin(div_pin), .pulse_pin(pulse_pin),
        .sub_clk(sub_clk), .carry(carry), .n_sub(n_sub), .n_trim(n_trim),
        .n_div(n_div), .n_pulse(n_pulse));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ****************************************
    // Bus, compare and report tasks
    // ****************************************
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic fail(input string w);
        n_errors++;
        $display("CHECK FAILED at %0t: %s", $time, w);
    endtask

    task automatic chk_byte(input reg_byte_t got, input reg_byte_t exp, input string w);
        tests_run++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", w, got, exp));
    endtask

    task automatic chk_cnt(input int got, input int exp, input string w);
        tests_run++;
        if (got != exp) fail($sformatf("%s got %0d exp %0d", w, got, exp));
    endtask

    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input reg_addr_t a, output reg_byte_t d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    task automatic rdc(input reg_addr_t a, input reg_byte_t e, input string w);
        reg_byte_t d;
        rd(a, d);
        chk_byte(d, e, w);
    endtask

    task automatic save(input reg_byte_t cmd = 8'h01);
        reg_byte_t d;
        wr(`OFF_XFER_CTRL, cmd);
        rdc(`OFF_XFER_STAT, 8'h01, "pending");
        rdc(`OFF_XFER_CTRL, cmd, "pending kind");
        for (int i = 0; i < 20; i++) begin
            rd(`OFF_XFER_STAT, d);
            if (d === 8'h00) return;
        end
        fail("save hang");
        tally_and_finish();
    endtask

    task automatic wait_run(input reg_byte_t e);
        reg_byte_t d;
        // A slow ratio may hold its level high for up to 64 sub periods
        for (int i = 0; i < 320; i++) begin
            rd(`OFF_DIV_CTRL, d);
            if ((d & 8'h02) === e) return;
        end
        fail("running flag hang");
        tally_and_finish();
    endtask

    task automatic sync_sub;
        logic [31:0] s;
        s = n_sub;
        for (int i = 0; i < 20 && n_sub == s; i++) @(posedge core_clk);
        if (n_sub == s) begin
            fail("sub clock hang");
            tally_and_finish();
        end
        repeat (3) @(posedge core_clk);
    endtask

    // Counts edges on every pin over n whole sub periods
    task automatic span(input int n);
        int s, t, v, p;
        sync_sub();
        s = n_sub;
        t = n_trim;
        v = n_div;
        p = n_pulse;
        repeat (n) sync_sub();
        d_sub = n_sub - s;
        d_trim = n_trim - t;
        d_div = n_div - v;
        d_pulse = n_pulse - p;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        vbat_rstn = 1'b0;
        stby = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        vbat_rstn <= 1'b1;
        for (int a = 0; a < 7; a++) rdc(a, 8'h00, "reset value");
        for (int a = 0; a < 7; a++) wr(a, 8'hFF);
        wr(4'h9, 8'hFF);
        for (int a = 0; a < 7; a++) rdc(a, msk[a], "reserved bits");
        rdc(4'h9, 8'h00, "unmapped");
        $display("test registers done");

        for (int c = 0; c < 5; c++) begin
            wr(`OFF_TRIM_LO, cfg[c][2] & 8'hFF);
            wr(`OFF_TRIM_HI, cfg[c][2] >> 8);
            wr(`OFF_TRIM_EN, cfg[c][0]);
            wr(`OFF_TRIM_PRD, cfg[c][1]);
            save();
            span((65 + cfg[c][1]) * SPS);
            span((cfg[c][1] + 1) * SPS);
            chk_cnt(d_sub - d_trim, cfg[c][0] * cfg[c][2], "drop");
        end
        wr(`OFF_TRIM_EN, 8'h00);
        save();
        $display("test trim done");

        for (int s = 0; s < 2; s++) begin
            wr(`OFF_PULSE_SEL, s);
            save();
            span(8 * SPS);
            chk_cnt(d_pulse, 16 >> s, "pulse edges");
        end
        $display("test pulse done");

        for (int n = 15; n >= 0; n--) begin
            wr(`OFF_DIV_CTRL, 8'h00);
            save();
            wait_run(8'h00);
            chk_byte({7'h0, div_pin}, 8'h00, "stopped pin");
            wr(`OFF_DIV_RATIO, n);
            wr(`OFF_DIV_CTRL, 8'h01);
            save();
            wait_run(8'h02);
            span(64);
            if (n < 7) chk_cnt(d_div, 64 >> n, "divided edges");
            else chk_cnt(d_div > 1, 0, "slow divide");
        end
        $display("test divider done");

        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rdc(`OFF_DIV_CTRL, 8'h02, "buffer cleared");
        rdc(`OFF_PULSE_SEL, 8'h00, "buffer cleared");
        span(64);
        chk_cnt(d_div, 64, "kept copy");
        // Recall refills the buffers from the battery copy before any later save
        save(8'h02);
        rdc(`OFF_DIV_CTRL, 8'h03, "recalled");
        rdc(`OFF_PULSE_SEL, 8'h01, "recalled");
        rdc(`OFF_TRIM_LO, 8'h05, "recalled");
        $display("test reset done");

        // Buffers are not saved here, so no rewrite is needed first
        @(posedge core_clk);
        stby <= 1'b1;
        span(64);
        chk_cnt(d_div, 0, "standby divided");
        chk_cnt(d_pulse, 0, "standby pulse");
        chk_byte({6'h0, div_pin, pulse_pin}, 8'h00, "standby levels");
        @(posedge core_clk);
        stby <= 1'b0;
        span(64);
        chk_cnt(d_div, 64, "resume divided");
        chk_cnt(d_pulse, 8, "resume pulse");
        $display("test standby done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
